// [rtl/pcrc_pkg.sv]
// Purpose: shared constants for the programmable crc generator
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package pcrc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CRC_CONTROL_ONE_OFS = 8'h00;
	localparam logic [7:0] CRC_CONTROL_TWO_OFS = 8'h04;
	localparam logic [7:0] POLY_TERMS_LOW_OFS  = 8'h08;
	localparam logic [7:0] POLY_TERMS_HIGH_OFS = 8'h0c;
	localparam logic [7:0] CRC_DATA_IN_OFS     = 8'h10;
	localparam logic [7:0] CRC_RESULT_OFS      = 8'h14;
	localparam logic [7:0] CRC_STATUS_OFS      = 8'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL1_START_BIT   = 0;
	localparam int CTL1_LENDIAN_BIT = 1;
	localparam int CTL1_CLEAR_BIT   = 2;
	localparam int CTL1_IEN_BIT     = 3;
	localparam int CTL1_IDONE_BIT   = 4;
	localparam int CTL2_PLEN_LSB    = 0;
	localparam int CTL2_DWID_LSB    = 8;
	localparam int STS_EMPTY_BIT    = 0;
	localparam int STS_FULL_BIT     = 1;
	localparam int STS_BUSY_BIT     = 2;
	localparam int STS_DONE_BIT     = 3;

	// ----------------------------------------------------------------
	// reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [4:0]  PLEN_RST   = 5'h0f;
	localparam logic [4:0]  DWID_RST   = 5'h07;
	localparam logic [15:0] TERMS_RST  = 16'h0000;
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;
	localparam int          FIFO_DEPTH = 4;

	typedef enum logic [2:0] {
		PCRC_IDLE  = 3'b001,
		PCRC_SHIFT = 3'b010,
		PCRC_NEXT  = 3'b100
	} pcrc_state_t;

endpackage : pcrc_pkg

// [rtl/pcrc_fifo.sv]
// Purpose: small data fifo in front of the crc shift engine
// Assumes: synchronous push and pop, flip-flop storage
// Notes:   push is ignored when full, pop when empty
`timescale 1ns/1ps
module pcrc_fifo
	import pcrc_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             en_i,
	// fill side
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output logic                  full_o,
	// drain side
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] rdata_o,
	output logic                  empty_o,
	output logic      [$clog2(DEPTH):0] count_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wptr_ff;
	logic [AW-1:0]    rptr_ff;
	logic [AW:0]      cnt_ff;
	logic             do_push;
	logic             do_pop;

	assign full_o  = (cnt_ff == (AW+1)'(DEPTH));
	assign empty_o = (cnt_ff == '0);
	assign count_o = cnt_ff;
	assign rdata_o = mem_ff[rptr_ff];
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;

	always_ff @(posedge clk_i) begin
		if (en_i && do_push) begin
			mem_ff[wptr_ff] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
		end else if (en_i) begin
			if (do_push) begin
				wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
			end
			if (do_pop) begin
				rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : pcrc_fifo

// [rtl/pcrc_top.sv]
// Purpose: programmable crc generator with apb register access
// Assumes: apb slave, one wait state, one clock domain
// Notes:   one data bit is shifted per clock cycle
//
// Notes on behaviour
// - crc in hardware for any order up to 32, order set by length field
// - each set term bit 1 .. n-1 adds xor feedback at that engine position; bits at n and above are masked off
// - zero-order term always fed back; term bit zero is ignored
// - top term n always used; no register bit for term 32
// - shift direction selectable, little-endian or big-endian
// - data word width set independently of polynomial length
// - data enters by fifo, engine in hardware, configurable interrupt
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module pcrc_top
	import pcrc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        en_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// interrupt
	output logic             crc_irq_o
);

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic        start_ff;
	logic        lendian_ff;
	logic        ien_ff;
	logic        idone_ff;
	logic        done_ff;
	logic [4:0]  plen_ff;
	logic [4:0]  dwid_ff;
	logic [15:0] terms_lo_ff;
	logic [15:0] terms_hi_ff;
	logic [31:0] crc_ff;
	logic [31:0] word_ff;
	logic [4:0]  bit_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        irq_ff;
	pcrc_state_t state_ff;

	logic        wr_acc;
	logic        rd_acc;
	logic        push;
	logic        pop;
	logic        f_full;
	logic        f_empty;
	logic [31:0] f_data;
	logic [31:0] poly;
	logic [31:0] mask;
	logic        din;
	logic        fb;
	logic [31:0] nxt_crc;
	logic        last_bit;
	logic        addr_ok;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// read data captured in the first access cycle; a write lands on the
	// edge where the master sees the registered pready high
	assign wr_acc = psel_i && penable_i && pwrite_i && pready_ff;
	assign rd_acc = psel_i && penable_i && !pwrite_i && !pready_ff;
	// a write already refused as full is not pushed
	assign push   = wr_acc && (paddr_i == CRC_DATA_IN_OFS)
		&& !pslverr_ff;
	assign addr_ok = (paddr_i == CRC_CONTROL_ONE_OFS)
		|| (paddr_i == CRC_CONTROL_TWO_OFS)
		|| (paddr_i == POLY_TERMS_LOW_OFS)
		|| (paddr_i == POLY_TERMS_HIGH_OFS)
		|| (paddr_i == CRC_DATA_IN_OFS)
		|| (paddr_i == CRC_RESULT_OFS)
		|| (paddr_i == CRC_STATUS_OFS);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else if (en_i) begin
			pready_ff  <= psel_i && penable_i && !pready_ff;
			pslverr_ff <= psel_i && penable_i && !pready_ff && (!addr_ok
				|| (pwrite_i && paddr_i == CRC_DATA_IN_OFS && f_full));
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (en_i && rd_acc) begin
			case (paddr_i)
				CRC_CONTROL_ONE_OFS: prdata_ff <= {27'h0, idone_ff, ien_ff,
					1'b0, lendian_ff, start_ff};
				CRC_CONTROL_TWO_OFS: prdata_ff <= {19'h0, dwid_ff, 3'h0,
					plen_ff};
				POLY_TERMS_LOW_OFS:  prdata_ff <= {16'h0, terms_lo_ff};
				POLY_TERMS_HIGH_OFS: prdata_ff <= {16'h0, terms_hi_ff};
				CRC_RESULT_OFS:      prdata_ff <= crc_ff & mask;
				CRC_STATUS_OFS:      prdata_ff <= {28'h0, done_ff,
					(state_ff != PCRC_IDLE), f_full, f_empty};
				default:             prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_ff    <= 1'b0;
			lendian_ff  <= 1'b0;
			ien_ff      <= 1'b0;
			idone_ff    <= 1'b0;
			plen_ff     <= PLEN_RST;
			dwid_ff     <= DWID_RST;
			terms_lo_ff <= TERMS_RST;
			terms_hi_ff <= TERMS_RST;
		end else if (en_i && wr_acc) begin
			case (paddr_i)
				CRC_CONTROL_ONE_OFS: begin
					start_ff   <= pwdata_i[CTL1_START_BIT];
					lendian_ff <= pwdata_i[CTL1_LENDIAN_BIT];
					ien_ff     <= pwdata_i[CTL1_IEN_BIT];
					idone_ff   <= pwdata_i[CTL1_IDONE_BIT];
				end
				CRC_CONTROL_TWO_OFS: begin
					plen_ff <= pwdata_i[CTL2_PLEN_LSB +: 5];
					dwid_ff <= pwdata_i[CTL2_DWID_LSB +: 5];
				end
				POLY_TERMS_LOW_OFS:  terms_lo_ff <= pwdata_i[15:0];
				POLY_TERMS_HIGH_OFS: terms_hi_ff <= pwdata_i[15:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// data fifo
	// ----------------------------------------------------------------
	pcrc_fifo #(
		.WIDTH (32),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.en_i    (en_i),
		.push_i  (push),
		.wdata_i (pwdata_i),
		.full_o  (f_full),
		.pop_i   (pop),
		.rdata_o (f_data),
		.empty_o (f_empty),
		.count_o ()
	);

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	// order n = plen + 1; mask covers bits 0 .. plen
	assign mask = 32'hffff_ffff >> (5'd31 - plen_ff);
	// bit 0 forced for the zero-order term
	assign poly = {terms_hi_ff, terms_lo_ff[15:1], 1'b1} & mask;
	assign din  = lendian_ff ? word_ff[bit_ff]
		: word_ff[dwid_ff - bit_ff];
	// top term n is implied by taking feedback from bit n-1
	assign fb   = crc_ff[plen_ff] ^ din;
	assign nxt_crc = (((crc_ff << 1) & mask) ^ (fb ? poly : 32'h0));
	assign last_bit = (bit_ff == dwid_ff);
	assign pop  = (state_ff == PCRC_IDLE || state_ff == PCRC_NEXT)
		&& start_ff && !f_empty;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff <= PCRC_IDLE;
			word_ff  <= 32'h0000_0000;
			bit_ff   <= 5'h00;
		end else if (en_i) begin
			case (state_ff)
				PCRC_IDLE, PCRC_NEXT: begin
					bit_ff <= 5'h00;
					if (pop) begin
						word_ff  <= f_data;
						state_ff <= PCRC_SHIFT;
					end else begin
						state_ff <= PCRC_IDLE;
					end
				end
				PCRC_SHIFT: begin
					bit_ff <= bit_ff + 5'h01;
					if (last_bit) begin
						state_ff <= PCRC_NEXT;
					end
				end
				default: state_ff <= PCRC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			crc_ff <= RESULT_RST;
		end else if (en_i) begin
			if (state_ff == PCRC_SHIFT) begin
				crc_ff <= nxt_crc;
			end else if (wr_acc && paddr_i == CRC_RESULT_OFS) begin
				crc_ff <= pwdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// done flag and interrupt
	// ----------------------------------------------------------------
	// done: set as the last bit shifts with the fifo empty; set wins over software clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_ff <= 1'b0;
			irq_ff  <= 1'b0;
		end else if (en_i) begin
			if (state_ff == PCRC_SHIFT && last_bit && f_empty) begin
				done_ff <= 1'b1;
			end else if (wr_acc && paddr_i == CRC_STATUS_OFS
				&& pwdata_i[STS_DONE_BIT]) begin
				done_ff <= 1'b0;
			end
			// interrupt on fifo empty or on shift done, per idone
			irq_ff <= ien_ff && (idone_ff ? done_ff : f_empty);
		end
	end

	assign prdata_o  = prdata_ff;
	assign pready_o  = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign crc_irq_o = irq_ff;

endmodule : pcrc_top

// [test/pcrc_assertions.sv]
// Purpose: port-level timing checks for the crc generator
// Assumes: one clock domain, reset async active low
// Notes:   bound into every pcrc_top instance
`timescale 1ns/1ps
module pcrc_chk (
	// clock, reset, enable
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        en_i,
	// apb
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        crc_irq_o
);
	// ----------------------------------------------------------------
	// access phase checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire req = psel_i && penable_i && !pready_o && en_i;
	wire map = paddr_i <= 8'h18 && paddr_i[1:0] == 2'h0;

	a_ready_next:
	assert property (req |=> pready_o)
	else $error("access not answered");
	a_ready_pulse:
	assert property (pready_o && en_i |=> !pready_o)
	else $error("ready longer than one cycle");
	a_ready_cause:
	assert property (pready_o |-> $past(psel_i && penable_i))
	else $error("ready without access");
	a_err_ready:
	assert property (pslverr_o |-> pready_o)
	else $error("error outside ready");
	a_unmap_err:
	assert property (req && paddr_i > 8'h18 |=> pslverr_o)
	else $error("unmapped access accepted");
	a_unmap_zero:
	assert property (req && !pwrite_i && paddr_i > 8'h18
		|=> prdata_o == 32'h0)
	else $error("unmapped read not zero");
	a_map_ok:
	assert property (req && map && paddr_i != 8'h10 |=> !pslverr_o)
	else $error("mapped access refused");
	a_rdata_hold:
	assert property ($changed(prdata_o) |-> pready_o)
	else $error("read data moved between reads");
endmodule : pcrc_chk

bind pcrc_top pcrc_chk u_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.crc_irq_o(crc_irq_o)
);

// [test/pcrc_tb_top.sv]
// Purpose: self-checking bench for the crc generator over apb
// Assumes: en_i high except a three-cycle freeze in each crc run, fifo depth from the package
// Notes:   expected crc from a bit-serial reference in the bench
`timescale 1ns/1ps
module pcrc_tb_top;
	import pcrc_pkg::*;
	logic        clk_i, nrst_i, en_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic        pready_o, pslverr_o, crc_irq_o, last_err;
	int          error_cnt, checked;

	pcrc_top #(.DEPTH(FIFO_DEPTH)) dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .crc_irq_o(crc_irq_o)
	);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		last_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	task automatic chk(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wait_done;
		logic [31:0] r;
		int k;
		k = 0;
		do begin
			apb(1'b0, CRC_STATUS_OFS, 32'h0, r);
			k++;
		end while (r[STS_DONE_BIT] !== 1'b1 && k < 300);
		chk(32'(r[STS_DONE_BIT]), 32'h1);
	endtask : wait_done
	function automatic logic [31:0] crc_f(input logic [31:0] c, p, d,
		input int pl, dw, input logic le);
		logic [31:0] m;
		logic fb;
		m = 32'hffff_ffff >> (31 - pl);
		p = (p | 32'h1) & m;
		c = c & m;
		for (int i = 0; i <= dw; i++) begin
			fb = c[pl] ^ (le ? d[i] : d[dw-i]);
			c = ((c << 1) & m) ^ (fb ? p : 32'h0);
		end
		return c;
	endfunction : crc_f
	task automatic run_crc(input int pl, dw, input logic le,
		input logic [31:0] t, s, d0, input int n);
		logic [31:0] e, d, r;
		wr(CRC_CONTROL_ONE_OFS, 32'h0);
		wr(CRC_CONTROL_TWO_OFS, 32'((dw << 8) | pl));
		wr(POLY_TERMS_LOW_OFS, {16'h0, t[15:0]});
		wr(POLY_TERMS_HIGH_OFS, {16'h0, t[31:16]});
		wr(CRC_RESULT_OFS, s);
		e = s;
		for (int k = 0; k < n; k++) begin
			d = d0 ^ (32'(k) * 32'h0103_0507);
			wr(CRC_DATA_IN_OFS, d);
			e = crc_f(e, t, d, pl, dw, le);
		end
		wr(CRC_CONTROL_ONE_OFS, {27'h0, 2'b11, 1'b0, le, 1'b1});
		// freeze the engine a few cycles; the result must not change
		en_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		en_i <= 1'b1;
		wait_done();
		apb(1'b0, CRC_RESULT_OFS, 32'h0, r);
		chk(r, e);
		chk(32'(crc_irq_o), 32'h1);
		wr(CRC_STATUS_OFS, 32'h8);
		repeat (2) @(posedge clk_i);
		chk(32'(crc_irq_o), 32'h0);
		wr(CRC_CONTROL_ONE_OFS, 32'h0);
		$display("test crc order %0d width %0d done", pl + 1, dw + 1);
	endtask : run_crc
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] r;
		apb(1'b0, CRC_CONTROL_TWO_OFS, 32'h0, r);
		chk(r, 32'h0000_070f);
		apb(1'b0, 8'h40, 32'h0, r);
		chk(r, 32'h0);
		chk(32'(last_err), 32'h1);
		$display("test regs done");
	endtask : t_regs
	task automatic t_fifo;
		logic [31:0] r;
		wr(CRC_CONTROL_ONE_OFS, 32'h8);
		repeat (2) @(posedge clk_i);
		chk(32'(crc_irq_o), 32'h1);
		for (int k = 0; k <= FIFO_DEPTH; k++) begin
			wr(CRC_DATA_IN_OFS, 32'(k));
			chk(32'(last_err), 32'(k == FIFO_DEPTH));
		end
		apb(1'b0, CRC_STATUS_OFS, 32'h0, r);
		chk(r & 32'h3, 32'h2);
		chk(32'(crc_irq_o), 32'h0);
		wr(CRC_CONTROL_ONE_OFS, 32'h1);
		wait_done();
		chk(32'(crc_irq_o), 32'h0);
		wr(CRC_STATUS_OFS, 32'h8);
		wr(CRC_CONTROL_ONE_OFS, 32'h0);
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_crc16;
		run_crc(15, 7, 1'b0, 32'h1020, 32'hffff, 32'hab31, 3);
	endtask : t_crc16
	task automatic t_crc32;
		run_crc(31, 31, 1'b1, 32'h04c1_1db6, 32'h0, 32'h1234_5678,
			4);
	endtask : t_crc32
	task automatic t_crc5;
		run_crc(4, 15, 1'b0, 32'h5, 32'h1f, 32'hc0de, 2);
	endtask : t_crc5
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// clock, reset, sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#500000;
		error_cnt++;
		stop_test();
	end
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i} = 4'h0;
		en_i = 1'b1;
		paddr_i = 8'h0;
		pwdata_i = 32'h0;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_fifo();
		t_crc16();
		t_crc32();
		t_crc5();
		stop_test();
	end
endmodule : pcrc_tb_top
